// >>> rtl/white_balance_control.v
// white balance control: register, sample grid, one-shot and auto loops, pixel gain
// assumes pixels, register port and capture control share clk
//
// Summary of operation
// - weaker channels gain up to 9.5 dB, 106 steps
// - presence bit reads one
// - absolute select takes external values instead
// - one-shot bit starts balance, self-clears when done
// - one-shot write ignored in auto mode
// - on bit switches feature, reads state
// - auto bit selects continuous mode, reads mode
// - correction writes ignored in auto or off
// - blue value toward blue, red toward red
// - sample grid over the work area
// - one-shot processes six frames
// - accumulate red, green, blue sums separately
// - pause, capture six, compute, restart
// - measurement frames output when stream enabled
// - restart previously active capture afterwards
// - computed corrections readable in register fields
// - auto mode updates corrections every frame
// - abort auto after ten second frame gap with external trigger
// - auto starts whether capturing or idle
// - control region independent; off follows image
// - invalid region switches itself off, flag shows
// - drive component sums toward equality
`timescale 1ns/10ps
`default_nettype none
`include "white_balance_map.vh"

module white_balance_control #(
    parameter PIX_W = 10,
    parameter DIM_W = 12,
    parameter GRID_SHIFT = 4,
    parameter TIMEOUT_CYCLES = `BAL_TIMEOUT_S * `BAL_CLK_HZ
) (
    input wire clk,
    input wire resetn,
    input wire csr_wr,
    input wire csr_rd,
    input wire [31:0] csr_addr,
    input wire [31:0] csr_wdata,
    output reg [31:0] csr_rdata,
    input wire [11:0] abs_blue,
    input wire [11:0] abs_red,
    input wire stream_enable,
    input wire ext_trigger,
    output reg capture_pause,
    output reg frame_request,
    output reg auto_abort,
    input wire [DIM_W-1:0] img_w,
    input wire [DIM_W-1:0] img_h,
    input wire region_on_req,
    input wire [DIM_W-1:0] region_x,
    input wire [DIM_W-1:0] region_y,
    input wire [DIM_W-1:0] region_w,
    input wire [DIM_W-1:0] region_h,
    output reg region_on,
    input wire pix_valid,
    input wire pix_sof,
    input wire pix_sol,
    input wire pix_eof,
    input wire [PIX_W-1:0] pix_data,
    output reg out_valid,
    output reg out_sof,
    output reg out_sol,
    output reg out_eof,
    output reg [PIX_W-1:0] out_data
);

localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_PAUSE = 5'h02;
localparam [4:0] ST_CAPTURE = 5'h04;
localparam [4:0] ST_CALC = 5'h08;
localparam [4:0] ST_RESTART = 5'h10;
localparam [29:0] TIMEOUT_LIM = TIMEOUT_CYCLES[29:0];
// gain in 2.8 fixed point: 1 + step * 4.75 / 256, 106 steps reach about 2.97
function [9:0] step_gain;
    input [11:0] step;
    reg [13:0] prod;
    begin
        prod = {2'h0, step} * 14'h0003;
        step_gain = `BAL_UNITY_GAIN + {step[7:0], 2'h0} + {2'h0, prod[9:2]};
    end
endfunction

reg on_reg;
reg auto_reg;
reg busy_reg;
reg [11:0] blue_reg;
reg [11:0] red_reg;
reg [4:0] state_reg;
reg [2:0] frame_cnt_reg;
reg wait_frame_reg;
reg [31:0] sum_r_reg;
reg [31:0] sum_g_reg;
reg [31:0] sum_b_reg;
reg [DIM_W-1:0] x_reg;
reg [DIM_W-1:0] y_reg;
reg [29:0] gap_cnt_reg;
reg csr_abs_sel;
wire bal_hit = (csr_addr == `BAL_OFFSET);
wire bal_wr = csr_wr && bal_hit;
////////////////////////////////////////////////////////////////////////////////
// work area and sample grid
wire [DIM_W-1:0] cur_x = pix_sol ? {DIM_W{1'b0}} : x_reg;
wire [DIM_W-1:0] cur_y = pix_sof ? {DIM_W{1'b0}} : (pix_sol ? y_reg + 1'b1 : y_reg);
wire [DIM_W:0] reg_x_end = {1'b0, region_x} + {1'b0, region_w};
wire [DIM_W:0] reg_y_end = {1'b0, region_y} + {1'b0, region_h};
// a region with zero size or reaching past the image is unusable
wire region_ok = (region_w != 0) && (region_h != 0) &&
    (reg_x_end <= {1'b0, img_w}) && (reg_y_end <= {1'b0, img_h});
wire [DIM_W-1:0] area_x = region_on ? region_x : {DIM_W{1'b0}};
wire [DIM_W-1:0] area_y = region_on ? region_y : {DIM_W{1'b0}};
wire [DIM_W-1:0] area_w = region_on ? region_w : img_w;
wire [DIM_W-1:0] area_h = region_on ? region_h : img_h;
wire [DIM_W-1:0] rel_x = cur_x - area_x;
wire [DIM_W-1:0] rel_y = cur_y - area_y;
wire in_area = (cur_x >= area_x) && (cur_y >= area_y) && (rel_x < area_w) && (rel_y < area_h);
// one 2x2 cell every 2^GRID_SHIFT pixels, shift 2 or more; 640x480 gives 1200 cells
wire on_grid = (rel_x[GRID_SHIFT-1:1] == 0) && (rel_y[GRID_SHIFT-1:1] == 0);
wire take_sample = pix_valid && in_area && on_grid;
wire is_red = !cur_y[0] && !cur_x[0];
wire is_blue = cur_y[0] && cur_x[0];
// region flag drops by itself when the area turns invalid
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        region_on <= 1'b0;
    end else begin
        region_on <= region_on_req && region_ok;
    end
end
// pixel position within the frame
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        x_reg <= {DIM_W{1'b0}};
        y_reg <= {DIM_W{1'b0}};
    end else if (pix_valid) begin
        x_reg <= cur_x + 1'b1;
        y_reg <= cur_y;
    end
end
////////////////////////////////////////////////////////////////////////////////
// effective gains and balance comparison
wire [11:0] eff_blue = csr_abs_sel ? abs_blue : blue_reg;
wire [11:0] eff_red = csr_abs_sel ? abs_red : red_reg;
wire [9:0] gain_b = on_reg ? step_gain(eff_blue) : `BAL_UNITY_GAIN;
wire [9:0] gain_r = on_reg ? step_gain(eff_red) : `BAL_UNITY_GAIN;
// measured sums weighted by the gains currently under trial
wire [41:0] wsum_b = sum_b_reg * step_gain(blue_reg);
wire [41:0] wsum_r = sum_r_reg * step_gain(red_reg);
// two green sites per cell, so half the green sum is the colourless target
wire [32:0] target = {2'h0, sum_g_reg[31:1]};
wire b_low = ({1'b0, wsum_b[40:8]} < {1'b0, target}) && (wsum_b[41] == 1'b0);
wire r_low = ({1'b0, wsum_r[40:8]} < {1'b0, target}) && (wsum_r[41] == 1'b0);
wire b_high = !b_low && ({1'b0, wsum_b[40:8]} != {1'b0, target});
wire r_high = !r_low && ({1'b0, wsum_r[40:8]} != {1'b0, target});
wire b_can_up = b_low && (blue_reg < `BAL_MAX_STEP);
wire r_can_up = r_low && (red_reg < `BAL_MAX_STEP);
// only the capture state, or auto mode while on, feeds the sums
wire accum_on = (state_reg == ST_CAPTURE && wait_frame_reg) || (auto_reg && on_reg);
wire frame_end = pix_valid && pix_eof;
////////////////////////////////////////////////////////////////////////////////
// component accumulators
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        sum_r_reg <= 32'h0000_0000;
        sum_g_reg <= 32'h0000_0000;
        sum_b_reg <= 32'h0000_0000;
    end else if ((state_reg == ST_PAUSE) || (auto_reg && pix_valid && pix_sof)) begin
        // restart sums before the six frames, or per frame in auto mode
        sum_r_reg <= 32'h0000_0000;
        sum_g_reg <= 32'h0000_0000;
        sum_b_reg <= 32'h0000_0000;
    end else if (accum_on && take_sample) begin
        if (is_red) begin
            sum_r_reg <= sum_r_reg + {{(32-PIX_W){1'b0}}, pix_data};
        end else if (is_blue) begin
            sum_b_reg <= sum_b_reg + {{(32-PIX_W){1'b0}}, pix_data};
        end else begin
            sum_g_reg <= sum_g_reg + {{(32-PIX_W){1'b0}}, pix_data};
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// control register, sequencer and auto loop
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        on_reg <= `BAL_ON_RESET;
        auto_reg <= `BAL_AUTO_RESET;
        csr_abs_sel <= 1'b0;
        busy_reg <= 1'b0;
        blue_reg <= `BAL_CORR_RESET;
        red_reg <= `BAL_CORR_RESET;
        state_reg <= ST_IDLE;
        frame_cnt_reg <= 3'h0;
        wait_frame_reg <= 1'b0;
        capture_pause <= 1'b0;
        frame_request <= 1'b0;
        auto_abort <= 1'b0;
        gap_cnt_reg <= 30'h0000_0000;
    end else begin
        frame_request <= 1'b0;
        auto_abort <= 1'b0;
        if (bal_wr) begin
            on_reg <= csr_wdata[`BAL_ON_BIT];
            auto_reg <= csr_wdata[`BAL_AUTO_BIT];
            csr_abs_sel <= csr_wdata[`BAL_ABS_BIT];
            // manual values only land while on and in manual mode
            if (on_reg && !auto_reg && !busy_reg) begin
                blue_reg <= csr_wdata[`BAL_BLUE_MSB:`BAL_BLUE_LSB];
                red_reg <= csr_wdata[`BAL_RED_MSB:`BAL_RED_LSB];
            end
        end
        case (state_reg)
            ST_IDLE: begin
                // a one-shot request in auto mode is dropped
                if (bal_wr && csr_wdata[`BAL_ONE_PUSH_BIT] && !auto_reg &&
                    !csr_wdata[`BAL_AUTO_BIT]) begin
                    busy_reg <= 1'b1;
                    capture_pause <= 1'b1;
                    state_reg <= ST_PAUSE;
                end
            end
            ST_PAUSE: begin
                // start from unity so the search climbs from the bottom
                blue_reg <= `BAL_CORR_RESET;
                red_reg <= `BAL_CORR_RESET;
                frame_cnt_reg <= 3'h0;
                frame_request <= 1'b1;
                wait_frame_reg <= 1'b1;
                state_reg <= ST_CAPTURE;
            end
            ST_CAPTURE: begin
                if (frame_end) begin
                    if (frame_cnt_reg == `BAL_FRAMES - 3'h1) begin
                        wait_frame_reg <= 1'b0;
                        state_reg <= ST_CALC;
                    end else begin
                        frame_cnt_reg <= frame_cnt_reg + 3'h1;
                        frame_request <= 1'b1;
                    end
                end
            end
            ST_CALC: begin
                // one step a cycle until each weighted sum reaches the target or its step reaches BAL_MAX_STEP
                if (b_can_up) begin
                    blue_reg <= blue_reg + 12'h001;
                end
                if (r_can_up) begin
                    red_reg <= red_reg + 12'h001;
                end
                if (!b_can_up && !r_can_up) begin
                    state_reg <= ST_RESTART;
                end
            end
            ST_RESTART: begin
                capture_pause <= 1'b0;
                busy_reg <= 1'b0;
                state_reg <= ST_IDLE;
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
        // auto loop: nudge each correction one step per frame
        if (auto_reg && on_reg && state_reg == ST_IDLE && !bal_wr) begin
            if (frame_end) begin
                gap_cnt_reg <= 30'h0000_0000;
                if (b_can_up) begin
                    blue_reg <= blue_reg + 12'h001;
                end else if (b_high && blue_reg != 12'h000) begin
                    blue_reg <= blue_reg - 12'h001;
                end
                if (r_can_up) begin
                    red_reg <= red_reg + 12'h001;
                end else if (r_high && red_reg != 12'h000) begin
                    red_reg <= red_reg - 12'h001;
                end
            end else if (ext_trigger) begin
                if (gap_cnt_reg >= TIMEOUT_LIM) begin
                    auto_reg <= 1'b0;
                    auto_abort <= 1'b1;
                    gap_cnt_reg <= 30'h0000_0000;
                end else begin
                    gap_cnt_reg <= gap_cnt_reg + 30'h0000_0001;
                end
            end
        end else begin
            gap_cnt_reg <= 30'h0000_0000;
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// register read port, unmapped addresses read zero
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        csr_rdata <= 32'h0000_0000;
    end else if (csr_rd) begin
        csr_rdata <= 32'h0000_0000;
        if (bal_hit) begin
            csr_rdata[`BAL_PRESENCE_BIT] <= 1'b1;
            csr_rdata[`BAL_ABS_BIT] <= csr_abs_sel;
            csr_rdata[`BAL_ONE_PUSH_BIT] <= busy_reg;
            csr_rdata[`BAL_ON_BIT] <= on_reg;
            csr_rdata[`BAL_AUTO_BIT] <= auto_reg;
            csr_rdata[`BAL_BLUE_MSB:`BAL_BLUE_LSB] <= blue_reg;
            csr_rdata[`BAL_RED_MSB:`BAL_RED_LSB] <= red_reg;
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// pixel gain: green stays at unity as the reference channel
wire [9:0] pix_gain = is_red ? gain_r : (is_blue ? gain_b : `BAL_UNITY_GAIN);
wire [PIX_W+9:0] pix_prod = pix_data * pix_gain;
wire pix_sat = |pix_prod[PIX_W+9:PIX_W+8];
// measurement frames go out too whenever the stream is enabled
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        out_valid <= 1'b0;
        out_sof <= 1'b0;
        out_sol <= 1'b0;
        out_eof <= 1'b0;
        out_data <= {PIX_W{1'b0}};
    end else begin
        out_valid <= pix_valid && stream_enable;
        out_sof <= pix_sof;
        out_sol <= pix_sol;
        out_eof <= pix_eof;
        out_data <= pix_sat ? {PIX_W{1'b1}} : pix_prod[PIX_W+7:8];
    end
end

endmodule
`default_nettype wire

// >>> rtl/white_balance_map.vh
// white balance control: register map, field positions, reset values, timing
// assumes the including file works at a 100 MHz clock
`ifndef WHITE_BALANCE_MAP_VH
`define WHITE_BALANCE_MAP_VH

// balance control register, byte address
`define BAL_OFFSET 32'hf0f0080c

// field positions, counted from the word's least significant bit as bit 0
`define BAL_PRESENCE_BIT 31
`define BAL_ABS_BIT 30
`define BAL_ONE_PUSH_BIT 26
`define BAL_ON_BIT 25
`define BAL_AUTO_BIT 24
`define BAL_BLUE_MSB 23
`define BAL_BLUE_LSB 12
`define BAL_RED_MSB 11
`define BAL_RED_LSB 0

// reset values
`define BAL_ON_RESET 1'b0
`define BAL_AUTO_RESET 1'b0
`define BAL_CORR_RESET 12'h000

// gain range: 106 steps reach about +9.5 dB
`define BAL_MAX_STEP 12'h06a
`define BAL_UNITY_GAIN 10'h100

// frames per single-shot measurement
`define BAL_FRAMES 3'h6

// frame gap that aborts auto balance with external trigger
`define BAL_TIMEOUT_S 10
`define BAL_CLK_HZ 100000000

`endif

// >>> tb/px_src.sv
// pixel source: one colour-pattern frame per request, idle between frames
// assumes the design's clock; start is a one-cycle request
`timescale 1ns/10ps
`default_nettype none
module px_src #(
    parameter W = 40,
    parameter H = 32,
    parameter [9:0] RV = 10'h0,
    parameter [9:0] GV = 10'h0,
    parameter [9:0] BV = 10'h0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic slow,
    output logic pix_valid,
    output logic pix_sof,
    output logic pix_sol,
    output logic pix_eof,
    output logic [9:0] pix_data
);
    logic [11:0] x, y;
    logic [5:0] dly;
    logic run;
    // idle data toggles so a stale pixel never looks steady
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {run, pix_valid, pix_sof, pix_sol, pix_eof} <= 5'h0;
            {x, y, dly, pix_data} <= 40'h0;
        end else begin
            pix_valid <= run;
            pix_sol <= run && x == 12'h0;
            pix_sof <= run && x == 12'h0 && y == 12'h0;
            pix_eof <= run && x == W - 1 && y == H - 1;
            pix_data <= !run ? ~pix_data : y[0] ? (x[0] ? BV : GV) : (x[0] ? GV : RV);
            if (run) begin
                x <= x == W - 1 ? 12'h0 : x + 12'h1;
                y <= x == W - 1 ? y + 12'h1 : y;
                run <= !(x == W - 1 && y == H - 1);
            end
            if (dly > 6'h1) dly <= dly - 6'h1;
            else if (dly == 6'h1) begin
                {dly, x, y} <= 30'h0;
                run <= 1'b1;
            end else if (start && !run) dly <= slow ? 6'h14 : 6'h2;
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// testbench: register, pixel gain, single-shot, auto and region sequences
// assumes px_src on the pixel side and wb_chk bound to the design
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam [31:0] MAP = 32'hf0f0080c;
    localparam [9:0] RV = 10'h0d2;
    localparam [9:0] GV = 10'h190;
    localparam [9:0] BV = 10'h15e;
    logic clk = 1'b0, resetn = 1'b0, csr_wr = 1'b0, csr_rd = 1'b0, stream_enable = 1'b0;
    logic ext_trigger = 1'b0, region_on_req = 1'b0, go = 1'b0, slow = 1'b0, chk_pix = 1'b0;
    logic [31:0] csr_addr = 32'h0, csr_wdata = 32'h0, rd_word, csr_rdata;
    logic [11:0] abs_blue = 12'h0, abs_red = 12'h0, img_w = 12'h028, img_h = 12'h020;
    logic [11:0] region_x = 12'h0, region_y = 12'h0, region_w = 12'h028, region_h = 12'h020;
    logic [11:0] gr_v = 12'h0, gb_v = 12'h0;
    logic capture_pause, frame_request, auto_abort, region_on, pix_valid, pix_sof, pix_sol;
    logic pix_eof, out_valid, out_sof, out_sol, out_eof;
    logic [9:0] pix_data, out_data;
    integer bad_count = 0, total_checks = 0, cycles = 0, n_req = 0, n_peof = 0, n_oeof = 0;
    integer n_abort = 0, row = 0, col = 0, i, k, m, e;
    always #5 clk = ~clk;
    white_balance_control #(.GRID_SHIFT(2), .TIMEOUT_CYCLES(200)) u_dut (.clk, .resetn,
        .csr_wr, .csr_rd, .csr_addr, .csr_wdata, .csr_rdata, .abs_blue, .abs_red,
        .stream_enable, .ext_trigger, .capture_pause, .frame_request, .auto_abort, .img_w,
        .img_h, .region_on_req, .region_x, .region_y, .region_w, .region_h, .region_on,
        .pix_valid, .pix_sof, .pix_sol, .pix_eof, .pix_data, .out_valid, .out_sof,
        .out_sol, .out_eof, .out_data);
    px_src #(.RV(RV), .GV(GV), .BV(BV)) u_src (.clk, .resetn, .start(frame_request | go),
        .slow, .pix_valid, .pix_sof, .pix_sol, .pix_eof, .pix_data);
    ////////////////////////////////////////////////////////////////////////////////
    function [11:0] gain(input [11:0] v);
        gain = 12'h100 + v * 4 + ((v * 3) >> 2);
    endfunction
    function [9:0] scale(input [9:0] p, input [11:0] v);
        reg [21:0] t;
        t = (p * gain(v)) >> 8;
        scale = t > 22'h3ff ? 10'h3ff : t[9:0];
    endfunction
    // smallest step whose gained sum reaches the green reference
    function [11:0] target(input [9:0] c);
        target = 12'h0;
        while (target < 12'h06a && gain(target) * c < GV * 24'h100) target = target + 1;
    endfunction
    function [31:0] wd(input on, au, push, ab, input [11:0] b, r);
        wd = {1'b0, ab, 3'h0, push, on, au, b, r};
    endfunction
    task chk(input [31:0] seen, exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task wr(input [31:0] a, d);
        begin
            @(posedge clk);
            {csr_wr, csr_addr, csr_wdata} <= {1'b1, a, d};
            @(posedge clk);
            csr_wr <= 1'b0;
        end
    endtask
    task rd(input [31:0] a);
        begin
            @(posedge clk);
            {csr_rd, csr_addr} <= {1'b1, a};
            @(posedge clk);
            csr_rd <= 1'b0;
            #1 rd_word = csr_rdata;
        end
    endtask
    // one frame on demand; two spare edges let the last pixel leave
    task frame;
        begin
            k = n_peof;
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            for (i = 0; i < 3000 && n_peof == k; i = i + 1) @(posedge clk);
            repeat (2) @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // event counters, output pixel position and gain check, run limit
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (frame_request) n_req = n_req + 1;
        if (pix_valid && pix_eof) n_peof = n_peof + 1;
        if (out_valid && out_eof) n_oeof = n_oeof + 1;
        if (auto_abort) n_abort = n_abort + 1;
        if (out_valid) begin
            if (out_sof) {row, col} = 64'h0;
            else if (out_sol) {row, col} = {row + 1, 32'h0};
            else col = col + 1;
            if (chk_pix) chk(out_data, row % 2 ? (col % 2 ? scale(BV, gb_v) : GV)
                : (col % 2 ? GV : scale(RV, gr_v)));
        end
        if (cycles == 40000) begin
            bad_count = bad_count + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd(MAP);
        chk(rd_word, 32'h80000000);
        rd(MAP + 4);
        chk(rd_word, 32'h0);
        wr(MAP + 4, wd(1, 0, 0, 0, 12'h5, 12'h7));
        wr(MAP, wd(1, 0, 0, 0, 12'h5, 12'h7));
        rd(MAP);
        chk(rd_word, 32'h82000000);
        wr(MAP, wd(1, 0, 0, 0, 12'h5, 12'h7));
        stream_enable <= 1'b1;
        {gb_v, gr_v, chk_pix} = {12'h5, 12'h7, 1'b1};
        frame;
        abs_blue <= 12'h06a;
        wr(MAP, wd(1, 0, 0, 1, 12'h5, 12'h7));
        {gb_v, gr_v} = {12'h06a, 12'h0};
        frame;
        rd(MAP);
        chk(rd_word, 32'hc2005007);
        wr(MAP, wd(0, 0, 0, 0, 12'h5, 12'h7));
        {gb_v, gr_v} = 24'h0;
        frame;
        chk_pix = 1'b0;
        wr(MAP, wd(1, 0, 0, 0, 12'h0, 12'h0));
        slow <= 1'b1;
        {m, e} = {n_req, n_oeof};
        wr(MAP, wd(1, 0, 1, 0, 12'h0, 12'h0));
        rd(MAP);
        chk(rd_word[26], 1'b1);
        for (i = 0; i < 20000 && capture_pause !== 1'b0; i = i + 1) @(posedge clk);
        chk(capture_pause, 1'b0);
        chk(n_req - m, 6);
        chk(n_oeof - e, 6);
        rd(MAP);
        chk(rd_word, {8'h82, target(BV), target(RV)});
        wr(MAP, wd(1, 1, 0, 0, 12'h0, 12'h0));
        slow <= 1'b0;
        wr(MAP, wd(1, 1, 1, 0, 12'h0, 12'h0));
        repeat (3) @(posedge clk);
        chk(capture_pause, 1'b0);
        repeat (3) frame;
        wr(MAP, wd(1, 1, 0, 0, 12'h9, 12'h9));
        rd(MAP);
        chk(rd_word, {8'h83, 12'h3, 12'h3});
        chk(n_abort, 0);
        @(posedge clk);
        ext_trigger <= 1'b1;
        repeat (260) @(posedge clk);
        chk(n_abort, 1);
        rd(MAP);
        chk(rd_word[24], 1'b0);
        @(posedge clk);
        region_on_req <= 1'b1;
        repeat (3) @(posedge clk);
        chk(region_on, 1'b1);
        region_x <= 12'h008;
        repeat (3) @(posedge clk);
        chk(region_on, 1'b0);
        give_verdict;
    end
endmodule
bind white_balance_control wb_chk u_chk (.clk, .resetn, .csr_wr, .csr_rd, .csr_addr,
    .csr_wdata, .csr_rdata, .stream_enable, .capture_pause, .frame_request, .auto_abort,
    .pix_valid, .pix_sof, .out_valid, .out_sof);
`default_nettype wire

// >>> tb/wb_chk.sv
// checker: register port, one-shot start and pixel timing relations
// assumes a bind to white_balance_control and a single clock domain
`timescale 1ns/10ps
`default_nettype none
module wb_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic csr_wr,
    input wire logic csr_rd,
    input wire logic [31:0] csr_addr,
    input wire logic [31:0] csr_wdata,
    input wire logic [31:0] csr_rdata,
    input wire logic stream_enable,
    input wire logic capture_pause,
    input wire logic frame_request,
    input wire logic auto_abort,
    input wire logic pix_valid,
    input wire logic pix_sof,
    input wire logic out_valid,
    input wire logic out_sof
);
    localparam [31:0] MAP = 32'hf0f0080c;
    logic hit;
    logic auto_q;
    assign hit = csr_addr == MAP;
    // mode copy: a mapped write loads it, an abort clears it and wins over a write in the same cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) auto_q <= 1'b0;
        else if (auto_abort) auto_q <= 1'b0;
        else if (csr_wr && hit) auto_q <= csr_wdata[24];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    property p_unmap;
        csr_rd && !hit |=> csr_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pres;
        csr_rd && hit |=> csr_rdata[31] && csr_rdata[29:27] == 3'h0;
    endproperty
    a_pres: assert property (p_pres) else $error("presence or spare bits wrong");
    property p_start;
        csr_wr && hit && csr_wdata[26] && !csr_wdata[24] && !auto_q && !capture_pause
            |=> capture_pause ##[1:2] frame_request;
    endproperty
    a_start: assert property (p_start) else $error("single shot did not start");
    property p_push_auto;
        csr_wr && hit && csr_wdata[26] && (auto_q || csr_wdata[24]) && !capture_pause
            |=> !capture_pause;
    endproperty
    a_push_auto: assert property (p_push_auto) else $error("push taken in auto");
    property p_req;
        frame_request |-> capture_pause ##1 !frame_request;
    endproperty
    a_req: assert property (p_req) else $error("frame request outside sequence");
    property p_abort;
        auto_abort |-> auto_q ##1 !auto_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not a pulse in auto");
    property p_out_on;
        pix_valid && stream_enable |=> out_valid && out_sof == $past(pix_sof);
    endproperty
    a_out_on: assert property (p_out_on) else $error("pixel not passed on");
    property p_out_off;
        !(pix_valid && stream_enable) |=> !out_valid;
    endproperty
    a_out_off: assert property (p_out_off) else $error("pixel out without input");
endmodule
`default_nettype wire
